/* File: shared/core_ctrl_pkg.sv */
// constants, opcodes, register map and state types of the control core
package core_ctrl_pkg;
  localparam int PC_W        = 15;
  localparam int INSTR_W     = 14;
  localparam int PTR_W       = 16;
  localparam int STACK_DEPTH = 16;
  localparam int SP_W        = 4;
  localparam int DIR_COUNT   = 8;

  // exact opcodes
  localparam logic [13:0] OP_IDLE_INSTR  = 14'h0000;
  localparam logic [13:0] OP_SOFT_RESET  = 14'h0001;
  localparam logic [13:0] OP_RETURN      = 14'h0008;
  localparam logic [13:0] OP_IRQ_RETURN  = 14'h0009;
  localparam logic [13:0] OP_CALL_ACC    = 14'h000A;
  localparam logic [13:0] OP_REL_ACC     = 14'h000B;
  localparam logic [13:0] OP_OPTION_LOAD = 14'h0062;
  localparam logic [13:0] OP_STANDBY     = 14'h0063;
  localparam logic [13:0] OP_WDT_KICK    = 14'h0064;
  // prefixes
  localparam logic [10:0] PFX_DIR_LOAD   = 11'h00C;
  localparam logic [10:0] PFX_IND_LOAD   = 11'h002;
  localparam logic [10:0] PFX_IND_STORE  = 11'h003;
  localparam logic [4:0]  PFX_REL_LIT    = 5'h19;
  localparam logic [2:0]  PFX_CALL       = 3'h4;
  localparam logic [2:0]  PFX_JUMP       = 3'h5;
  localparam logic [5:0]  PFX_RET_LIT    = 6'h34;
  localparam logic [6:0]  PFX_PTR_ADD    = 7'h62;
  localparam logic [6:0]  PFX_IDX_LOAD   = 7'h7E;
  localparam logic [6:0]  PFX_IDX_STORE  = 7'h7F;
  localparam logic [5:0]  PFX_AND_LIT    = 6'h39;
  localparam logic [5:0]  PFX_SUM_LIT    = 6'h3E;

  // register map, byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ACC    = 8'h08;
  localparam logic [7:0] REG_PTR0   = 8'h0C;
  localparam logic [7:0] REG_PTR1   = 8'h10;
  localparam logic [7:0] REG_OPTION = 8'h14;
  localparam logic [7:0] REG_DIR_LO = 8'h18;
  localparam logic [7:0] REG_DIR_HI = 8'h1C;

  // status word fields
  localparam int ST_C       = 0;
  localparam int ST_DC      = 1;
  localparam int ST_Z       = 2;
  localparam int ST_PD      = 3;
  localparam int ST_TO      = 4;
  localparam int ST_GIE     = 5;
  localparam int ST_STANDBY = 6;
  localparam int ST_RUN     = 7;
  localparam int ST_PC_LSB  = 16;
  localparam int CTRL_RUN   = 0;

  localparam logic [7:0]       OPTION_RST = 8'hFF;
  localparam logic [7:0]       DIR_RST    = 8'hFF;
  localparam logic [PC_W-1:0]  PC_RST     = 15'h0000;
  localparam logic [PTR_W-1:0] PTR_RST    = 16'h0000;
  localparam logic [PTR_W-1:0] PTR_ONE    = 16'h0001;
  localparam int               PTR_MSB    = 15;

  typedef enum logic [1:0] {PH_EXEC, PH_FLUSH, PH_STRETCH} phase_t;

  typedef enum logic [4:0] {
    OPC_IDLE, OPC_SRESET, OPC_RET, OPC_IRET, OPC_CALL_VIA_ACC, OPC_RELW, OPC_OPTION, OPC_STANDBY,
    OPC_KICK, OPC_DIR, OPC_ILOAD, OPC_ISTORE, OPC_REL, OPC_CALL, OPC_JUMP, OPC_RETLIT,
    OPC_PADD, OPC_XLOAD, OPC_XSTORE, OPC_AND, OPC_SUM, OPC_OTHER
  } op_t;

  typedef struct packed {
    logic [PC_W-1:0]                    pc;
    logic [7:0]                         acc;
    logic                               c;
    logic                               dc;
    logic                               z;
    logic                               to;
    logic                               pd;
    logic                               gie;
    logic                               standby;
    logic                               run;
    logic [PTR_W-1:0]                   ptr0;
    logic [PTR_W-1:0]                   ptr1;
    logic [7:0]                         option;
    logic [DIR_COUNT-1:0][7:0]          dir;
    logic [STACK_DEPTH-1:0][PC_W-1:0]   stack;
    logic [SP_W-1:0]                    sp;
    phase_t                             phase;
    logic [15:0]                        wdt_cnt;
    logic                               soft_rst;
    logic                               kick;
    logic                               wdt_to;
    logic                               bus_wr;
    logic [7:0]                         bus_addr;
    logic [31:0]                        hrdata;
  } state_t;
endpackage : core_ctrl_pkg

/* File: src/core_ctrl.sv */
// control-flow, inherent and indirect execution core with ahb-lite register slave
`timescale 1ns/100ps
module core_ctrl import core_ctrl_pkg::*; #(
  parameter int WDT_LIMIT = 4000
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // program memory
  output logic [PC_W-1:0]           pmem_addr,
  input  wire logic [INSTR_W-1:0]   pmem_data,
  // data memory
  output logic [PTR_W-1:0]          dmem_addr,
  output logic [7:0]                dmem_wdata,
  output logic                      dmem_we,
  output logic                      dmem_re,
  input  wire logic [7:0]           dmem_rdata,
  // system
  input  wire logic                 wake,
  output logic                      soft_reset,
  output logic                      wdt_kick,
  output logic                      wdt_timeout,
  output logic                      standby,
  output logic [7:0]                option_out
);

  localparam logic [15:0] WDT_TOP = 16'(WDT_LIMIT - 1);

  state_t s_q;
  state_t s_d;

  // ****************************************
  // helpers
  // ****************************************
  function automatic op_t decode(input logic [13:0] i);
    op_t o;
    o = OPC_OTHER;
    if (i == OP_IDLE_INSTR) o = OPC_IDLE;
    else if (i == OP_SOFT_RESET) o = OPC_SRESET;
    else if (i == OP_RETURN) o = OPC_RET;
    else if (i == OP_IRQ_RETURN) o = OPC_IRET;
    else if (i == OP_CALL_ACC) o = OPC_CALL_VIA_ACC;
    else if (i == OP_REL_ACC) o = OPC_RELW;
    else if (i == OP_OPTION_LOAD) o = OPC_OPTION;
    else if (i == OP_STANDBY) o = OPC_STANDBY;
    else if (i == OP_WDT_KICK) o = OPC_KICK;
    else if (i[13:3] == PFX_DIR_LOAD) o = OPC_DIR;
    else if (i[13:3] == PFX_IND_LOAD) o = OPC_ILOAD;
    else if (i[13:3] == PFX_IND_STORE) o = OPC_ISTORE;
    else if (i[13:9] == PFX_REL_LIT) o = OPC_REL;
    else if (i[13:11] == PFX_CALL) o = OPC_CALL;
    else if (i[13:11] == PFX_JUMP) o = OPC_JUMP;
    else if (i[13:8] == PFX_RET_LIT) o = OPC_RETLIT;
    else if (i[13:7] == PFX_PTR_ADD) o = OPC_PADD;
    else if (i[13:7] == PFX_IDX_LOAD) o = OPC_XLOAD;
    else if (i[13:7] == PFX_IDX_STORE) o = OPC_XSTORE;
    else if (i[13:8] == PFX_AND_LIT) o = OPC_AND;
    else if (i[13:8] == PFX_SUM_LIT) o = OPC_SUM;
    return o;
  endfunction : decode

  // sign-extended six-bit literal added modulo 2^16
  function automatic logic [PTR_W-1:0] ptr_offset(input logic [PTR_W-1:0] p, input logic [5:0] k);
    return p + {{10{k[5]}}, k};
  endfunction : ptr_offset

  // registers are whole words: drop the byte lane
  function automatic logic [7:0] word_addr(input logic [31:0] a);
    return {a[7:2], 2'b00};
  endfunction : word_addr

  function automatic logic [31:0] read_mux(input state_t s, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      REG_CTRL: r[CTRL_RUN] = s.run;
      REG_STATUS: begin
        r[ST_C]       = s.c;
        r[ST_DC]      = s.dc;
        r[ST_Z]       = s.z;
        r[ST_PD]      = s.pd;
        r[ST_TO]      = s.to;
        r[ST_GIE]     = s.gie;
        r[ST_STANDBY] = s.standby;
        r[ST_RUN]     = s.run;
        r[ST_PC_LSB +: PC_W] = s.pc;
      end
      REG_ACC:    r[7:0]  = s.acc;
      REG_PTR0:   r[15:0] = s.ptr0;
      REG_PTR1:   r[15:0] = s.ptr1;
      REG_OPTION: r[7:0]  = s.option;
      REG_DIR_LO: r = {s.dir[3], s.dir[2], s.dir[1], s.dir[0]};
      REG_DIR_HI: r = {s.dir[7], s.dir[6], s.dir[5], s.dir[4]};
      default:    r = 32'h0000_0000;
    endcase
    return r;
  endfunction : read_mux

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    op_t              op;
    logic [PC_W-1:0]  pc_inc;
    logic             n;
    logic [PTR_W-1:0] p;
    logic [PTR_W-1:0] p_mod;
    logic [PTR_W-1:0] ea;
    logic [8:0]       sum;
    logic [4:0]       half;
    logic [SP_W-1:0]  sp_dn;
    logic [7:0]       lit;
    s_d        = s_q;
    op         = decode(pmem_data);
    pc_inc     = s_q.pc + 15'h0001;
    n          = 1'b0;
    p          = PTR_RST;
    p_mod      = PTR_RST;
    ea         = PTR_RST;
    lit        = pmem_data[7:0];
    sum        = {1'b0, s_q.acc} + {1'b0, lit};
    half       = {1'b0, s_q.acc[3:0]} + {1'b0, lit[3:0]};
    sp_dn      = s_q.sp - 4'h1;
    dmem_addr  = PTR_RST;
    dmem_wdata = s_q.acc;
    dmem_we    = 1'b0;
    dmem_re    = 1'b0;
    s_d.soft_rst = 1'b0;
    s_d.kick     = 1'b0;
    s_d.wdt_to   = 1'b0;

    // watchdog counter runs while the core is enabled
    if (s_q.run) begin
      if (s_q.wdt_cnt == WDT_TOP) begin
        s_d.wdt_cnt = 16'h0000;
        s_d.to      = 1'b0;
        s_d.wdt_to  = 1'b1;
      end else begin
        s_d.wdt_cnt = s_q.wdt_cnt + 16'h0001;
      end
    end

    if (s_q.standby && wake) begin
      s_d.standby = 1'b0;
    end

    if (s_q.run && !s_q.standby) begin
      case (s_q.phase)
        PH_FLUSH, PH_STRETCH: begin
          s_d.phase = PH_EXEC;
        end
        PH_EXEC: begin
          s_d.pc = pc_inc;
          case (op)
            OPC_IDLE, OPC_OTHER: begin
              s_d.pc = pc_inc;
            end
            OPC_REL: begin
              s_d.pc    = pc_inc + {{6{pmem_data[8]}}, pmem_data[8:0]};
              s_d.phase = PH_FLUSH;
            end
            OPC_RELW: begin
              s_d.pc    = pc_inc + {7'h00, s_q.acc};
              s_d.phase = PH_FLUSH;
            end
            OPC_CALL, OPC_CALL_VIA_ACC: begin
              s_d.stack[s_q.sp] = pc_inc;
              s_d.sp = s_q.sp + 4'h1;
              if (op == OPC_CALL) s_d.pc = {s_q.pc[14:11], pmem_data[10:0]};
              else s_d.pc = {s_q.pc[14:8], s_q.acc};
              s_d.phase = PH_FLUSH;
            end
            OPC_JUMP: begin
              s_d.pc    = {s_q.pc[14:11], pmem_data[10:0]};
              s_d.phase = PH_FLUSH;
            end
            OPC_RET, OPC_IRET, OPC_RETLIT: begin
              s_d.pc    = s_q.stack[sp_dn];
              s_d.sp    = sp_dn;
              s_d.phase = PH_FLUSH;
              if (op == OPC_IRET) s_d.gie = 1'b1;
              if (op == OPC_RETLIT) s_d.acc = lit;
            end
            OPC_KICK: begin
              s_d.wdt_cnt = 16'h0000;
              s_d.wdt_to  = 1'b0;
              s_d.kick    = 1'b1;
              s_d.to      = 1'b1;
              s_d.pd      = 1'b1;
            end
            OPC_OPTION: begin
              s_d.option = s_q.acc;
            end
            OPC_SRESET: begin
              s_d.pc       = PC_RST;
              s_d.acc      = 8'h00;
              s_d.sp       = 4'h0;
              s_d.ptr0     = PTR_RST;
              s_d.ptr1     = PTR_RST;
              s_d.option   = OPTION_RST;
              s_d.dir      = {DIR_COUNT{DIR_RST}};
              s_d.gie      = 1'b0;
              s_d.soft_rst = 1'b1;
            end
            OPC_STANDBY: begin
              s_d.standby = 1'b1;
              s_d.to      = 1'b1;
              s_d.pd      = 1'b0;
              s_d.wdt_cnt = 16'h0000;
              s_d.wdt_to  = 1'b0;
            end
            OPC_DIR: begin
              s_d.dir[pmem_data[2:0]] = s_q.acc;
            end
            OPC_PADD: begin
              if (pmem_data[6]) s_d.ptr1 = ptr_offset(s_q.ptr1, pmem_data[5:0]);
              else s_d.ptr0 = ptr_offset(s_q.ptr0, pmem_data[5:0]);
            end
            OPC_ILOAD, OPC_ISTORE, OPC_XLOAD, OPC_XSTORE: begin
              if (op == OPC_ILOAD || op == OPC_ISTORE) begin
                n     = pmem_data[2];
                p     = n ? s_q.ptr1 : s_q.ptr0;
                p_mod = pmem_data[0] ? p - PTR_ONE : p + PTR_ONE;
                ea    = pmem_data[1] ? p : p_mod;
                if (n) s_d.ptr1 = p_mod;
                else s_d.ptr0 = p_mod;
              end else begin
                n  = pmem_data[6];
                p  = n ? s_q.ptr1 : s_q.ptr0;
                ea = ptr_offset(p, pmem_data[5:0]);
              end
              dmem_addr = ea;
              if (op == OPC_ILOAD || op == OPC_XLOAD) begin
                dmem_re = 1'b1;
                s_d.acc = dmem_rdata;
                s_d.z   = (dmem_rdata == 8'h00);
              end else begin
                dmem_we = 1'b1;
              end
              if (ea[PTR_MSB]) s_d.phase = PH_STRETCH;
            end
            OPC_AND: begin
              s_d.acc = s_q.acc & lit;
              s_d.z   = ((s_q.acc & lit) == 8'h00);
            end
            OPC_SUM: begin
              s_d.acc = sum[7:0];
              s_d.c   = sum[8];
              s_d.dc  = half[4];
              s_d.z   = (sum[7:0] == 8'h00);
            end
            default: begin
              s_d.pc = pc_inc;
            end
          endcase
        end
        default: begin
          s_d.phase = PH_EXEC;
        end
      endcase
    end

    // a timeout landing with a kick or standby still counts
    if (s_q.run && s_q.wdt_cnt == WDT_TOP) begin
      s_d.wdt_to = 1'b1;
      s_d.to     = 1'b0;
    end

    // ****************************************
    // bus slave: data-phase writes win over core
    // ****************************************
    if (s_q.bus_wr) begin
      case (s_q.bus_addr)
        REG_CTRL: s_d.run  = hwdata[CTRL_RUN];
        REG_ACC:  s_d.acc  = hwdata[7:0];
        REG_PTR0: s_d.ptr0 = hwdata[15:0];
        REG_PTR1: s_d.ptr1 = hwdata[15:0];
        default:  s_d.run  = s_d.run;
      endcase
    end
    s_d.bus_wr = 1'b0;
    if (hsel && hready && htrans[1]) begin
      s_d.bus_wr   = hwrite;
      s_d.bus_addr = word_addr(haddr);
      if (!hwrite) s_d.hrdata = read_mux(s_q, word_addr(haddr));
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q          <= '0;
      s_q.pc       <= PC_RST;
      s_q.to       <= 1'b1;
      s_q.pd       <= 1'b1;
      s_q.option   <= OPTION_RST;
      s_q.dir      <= {DIR_COUNT{DIR_RST}};
      s_q.phase    <= PH_EXEC;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign hrdata      = s_q.hrdata;
  assign pmem_addr   = s_q.pc;
  assign soft_reset  = s_q.soft_rst;
  assign wdt_kick    = s_q.kick;
  assign wdt_timeout = s_q.wdt_to;
  assign standby     = s_q.standby;
  assign option_out  = s_q.option;

endmodule : core_ctrl

/* File: bench/core_ctrl_properties.sv */
// checker of control-flow, inherent and indirect execution timing
`timescale 1ns/100ps
module core_ctrl_properties import core_ctrl_pkg::*; #(
  parameter int WDT_LIMIT = 4000
) (
  // clock and reset
  input wire logic               hclk,
  input wire logic               hresetn,
  // memories
  input wire logic [PC_W-1:0]    pmem_addr,
  input wire logic [INSTR_W-1:0] pmem_data,
  input wire logic [PTR_W-1:0]   dmem_addr,
  input wire logic [7:0]         dmem_wdata,
  input wire logic               dmem_we,
  input wire logic               dmem_re,
  // system
  input wire logic               wdt_kick,
  input wire logic               standby,
  input wire logic [7:0]         option_out
);
  // ****************
  // execute cycle tracking
  // ****************
  logic [PC_W-1:0]    pc_q;
  logic               strb_q;
  logic               exec;
  logic [INSTR_W-1:0] op;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q   <= '0;
      strb_q <= 1'b0;
    end else begin
      pc_q   <= pmem_addr;
      strb_q <= dmem_re | dmem_we;
    end
  end
  // a plain step of one makes the next cycle an execute cycle
  assign exec = !standby && !strb_q && (pmem_addr == pc_q + 15'h1);
  assign op   = pmem_data;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************
  // assertions
  // ****************
  a_jump_target: assert property (exec && op[13:11] == PFX_JUMP
    |=> pmem_addr == {$past(pmem_addr[14:11]), $past(pmem_data[10:0])} ##1 $stable(pmem_addr))
    else $error("jump target or idle cycle wrong");
  a_call_target: assert property (exec && op[13:11] == PFX_CALL
    |=> pmem_addr == {$past(pmem_addr[14:11]), $past(pmem_data[10:0])} ##1 $stable(pmem_addr))
    else $error("call target or idle cycle wrong");
  a_rel_idle: assert property (exec && op[13:9] == PFX_REL_LIT |=> ##1 $stable(pmem_addr))
    else $error("relative jump lacks idle cycle");
  a_kick_pulse: assert property (exec && op == OP_WDT_KICK |=> wdt_kick ##1 !wdt_kick)
    else $error("watchdog kick pulse wrong");
  a_standby_entry: assert property (exec && op == OP_STANDBY |=> standby)
    else $error("standby not entered");
  a_option_copy: assert property (exec && op == OP_OPTION_LOAD |=> option_out == $past(dmem_wdata))
    else $error("option not loaded from accumulator");
  a_load_strobe: assert property (exec && (op[13:3] == PFX_IND_LOAD || op[13:7] == PFX_IDX_LOAD)
    |-> dmem_re && !dmem_we)
    else $error("indirect load strobe wrong");
  a_store_strobe: assert property (exec && (op[13:3] == PFX_IND_STORE || op[13:7] == PFX_IDX_STORE)
    |-> dmem_we && !dmem_re)
    else $error("indirect store strobe wrong");
  a_stretch_once: assert property ((dmem_re || dmem_we) && dmem_addr[PTR_MSB]
    |=> !dmem_re && !dmem_we ##1 pmem_addr == $past(pmem_addr, 2) + 15'h1)
    else $error("high pointer access not stretched once");
  c_stretch: cover property ((dmem_re || dmem_we) && dmem_addr[PTR_MSB]);
  c_call: cover property (exec && op[13:11] == PFX_CALL);
  c_standby: cover property ($rose(standby));
endmodule : core_ctrl_properties

bind core_ctrl core_ctrl_properties #(.WDT_LIMIT(WDT_LIMIT)) u_core_ctrl_properties (
  .hclk(hclk), .hresetn(hresetn), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
  .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_re(dmem_re),
  .wdt_kick(wdt_kick), .standby(standby), .option_out(option_out)
);

/* File: bench/core_mem.sv */
// program and data memory model seen by the core
`timescale 1ns/100ps
module core_mem import core_ctrl_pkg::*; (
  // clock
  input wire logic               hclk,
  // program memory
  input wire logic [PC_W-1:0]    pmem_addr,
  output logic [INSTR_W-1:0]     pmem_data,
  // data memory
  input wire logic [PTR_W-1:0]   dmem_addr,
  input wire logic [7:0]         dmem_wdata,
  input wire logic               dmem_we,
  input wire logic               dmem_re,
  output logic [7:0]             dmem_rdata
);
  logic [INSTR_W-1:0] prog [0:255];
  logic [7:0]         data_mem [0:65535];
  logic [7:0]         last_q = 8'h00;
  assign pmem_data  = prog[pmem_addr[7:0]];
  // idle read bus shows inverse of last value
  assign dmem_rdata = dmem_re ? data_mem[dmem_addr] : ~last_q;
  always @(posedge hclk) begin
    if (dmem_we) begin
      data_mem[dmem_addr] <= dmem_wdata;
    end
    if (dmem_re) begin
      last_q <= data_mem[dmem_addr];
    end
  end
endmodule : core_mem

/* File: bench/tb_top.sv */
// register-bus driven testbench of the control core
`timescale 1ns/100ps
module tb_top import core_ctrl_pkg::*; ;
  localparam logic [13:0] MAIN [17] = '{14'h3EF3, 14'h3900, 14'h3105, 14'h317F, 14'h0062, 14'h0065,
    14'h0064, 14'h3F40, 14'h0000, 14'h001A, 14'h0000, 14'h0011, 14'h0000, 14'h3201, 14'h0000,
    14'h0000, 14'h2820};
  localparam logic [13:0] SUB [3] = '{14'h0000, 14'h2030, 14'h000B};
  logic               hclk;
  logic               hresetn;
  logic               hsel;
  logic               hwrite;
  logic               wake;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        haddr;
  logic [31:0]        hwdata;
  logic               hreadyout;
  logic               hresp;
  logic [31:0]        hrdata;
  logic [PC_W-1:0]    pmem_addr;
  logic [INSTR_W-1:0] pmem_data;
  logic [PTR_W-1:0]   dmem_addr;
  logic [7:0]         dmem_wdata;
  logic               dmem_we;
  logic               dmem_re;
  logic [7:0]         dmem_rdata;
  logic               standby;
  logic               soft_reset;
  logic [7:0]         option_out;
  int                 err_total = 0;
  int                 compares = 0;
  int                 cycles = 0;

  core_ctrl #(.WDT_LIMIT(4000)) u_core_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
    .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_re(dmem_re),
    .dmem_rdata(dmem_rdata), .wake(wake), .soft_reset(soft_reset), .wdt_kick(), .wdt_timeout(),
    .standby(standby), .option_out(option_out));
  core_mem u_core_mem (.hclk(hclk), .pmem_addr(pmem_addr), .pmem_data(pmem_data), .dmem_addr(dmem_addr),
    .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_re(dmem_re), .dmem_rdata(dmem_rdata));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ****************
  // tasks
  // ****************
  task automatic tally_and_finish();
    $display("counts: compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] data);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    data = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, exp, what);
  endtask : rd_chk
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      $display("BAD t=%0t timeout", $time);
      tally_and_finish();
    end
  end
  // ****************
  // tests
  // ****************
  initial begin
    int n;
    hresetn = 1'b0;
    hsel    = 1'b0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    haddr   = 32'h0;
    hwdata  = 32'h0;
    wake    = 1'b0;
    for (int i = 0; i < 256; i++) u_core_mem.prog[i] = OP_IDLE_INSTR;
    for (int i = 0; i < 17; i++) u_core_mem.prog[i] = MAIN[i];
    for (int i = 0; i < 3; i++) u_core_mem.prog[32+i] = SUB[i];
    u_core_mem.prog[48] = 14'h3477;
    // acc relative jump to 154, acc call to 119, nested call, plain and interrupt return
    u_core_mem.prog[119] = 14'h2079;
    u_core_mem.prog[120] = 14'h0009;
    u_core_mem.prog[121] = 14'h0008;
    u_core_mem.prog[154] = 14'h000A;
    u_core_mem.prog[156] = 14'h0063;
    u_core_mem.prog[157] = 14'h289D;
    u_core_mem.data_mem[16'hFFFF] = 8'h5A;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(REG_STATUS, 32'h00000018, "status reset");
    rd_chk(REG_OPTION, 32'h000000FF, "option reset");
    rd_chk(REG_DIR_LO, 32'hFFFFFFFF, "dir reset");
    wr(REG_OPTION, 32'h00000012);
    rd_chk(REG_OPTION, 32'h000000FF, "option read only");
    rd_chk(8'h40, 32'h0, "unmapped");
    check({31'h0, hresp}, 32'h0, "okay response");
    $display("test reset_map done");
    wr(REG_ACC, 32'h0F);
    wr(REG_PTR0, 32'hFFFE);
    wr(REG_PTR1, 32'h0);
    wr(REG_CTRL, 32'h1);
    for (n = 0; n < 200 && standby !== 1'b1; n++) @(posedge hclk);
    check({31'h0, standby}, 32'h1, "standby entry");
    wake <= 1'b1;
    repeat (2) @(posedge hclk);
    wake <= 1'b0;
    repeat (4) @(posedge hclk);
    check({31'h0, standby}, 32'h0, "standby exit");
    rd_chk(REG_ACC, 32'h77, "return literal");
    rd_chk(REG_PTR0, 32'h0003, "ptr0 modifiers");
    rd_chk(REG_PTR1, 32'hFFFF, "ptr1 add wrap");
    rd_chk(REG_OPTION, 32'h00, "option load");
    rd_chk(REG_DIR_HI, 32'hFFFF00FF, "dir load");
    rd_chk(REG_STATUS, 32'h009D00B3, "status flags");
    check({24'h0, u_core_mem.data_mem[3]}, 32'h5A, "indirect store");
    $display("test program done");
    @(negedge hclk);
    u_core_mem.prog[0]   = 14'h2800;
    u_core_mem.prog[157] = OP_SOFT_RESET;
    for (n = 0; n < 50 && soft_reset !== 1'b1; n++) @(posedge hclk);
    check({31'h0, soft_reset}, 32'h1, "soft reset pulse");
    rd_chk(REG_ACC, 32'h0, "reset acc");
    rd_chk(REG_PTR0, 32'h0, "reset ptr0");
    rd_chk(REG_OPTION, 32'hFF, "reset option");
    rd_chk(REG_DIR_HI, 32'hFFFFFFFF, "reset dir");
    rd_chk(REG_STATUS, 32'h00000093, "reset status");
    $display("test soft_reset done");
    tally_and_finish();
  end
endmodule : tb_top
